// ### rtl/afc_formatter.sv
// Sample output formatter with APB control
`timescale 1ns/1ps
`default_nettype none
module afc_formatter import afc_pkg::*; (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              encode_clock_pos,
   input  wire logic [CODE_W-1:0] core_code,
   input  wire logic              core_over,
   input  wire logic              core_under,
   output logic      [CODE_W-1:0] bus_a_bits,
   output logic      [CODE_W-1:0] bus_b_bits,
   output logic                   bus_a_range_flag,
   output logic                   bus_b_range_flag,
   output logic                   bus_a_forwarded_clock,
   output logic                   bus_b_forwarded_clock,
   output logic                   forwarded_sample_clock,
   output logic                   forwarded_sample_clock_n,
   output logic                   range_overflow_flag,
   output logic                   range_overflow_flag_n,
   output logic                   out_en,
   output logic                   data_ready
);
   logic [14:0]       pin_s;
   logic              enc_s, enc_prev_q, ovr_s, und_s;
   logic [11:0]       code_s;
   logic              rise_ev, fall_ev;
   logic [5:0]        ctrl_q;
   logic [1:0]        mode, fmt_sel;
   logic              twos, stab_on, oe_n_q, pd_q, nap, is_full, is_lvds, is_inter, is_simul;
   logic [CNT_W-1:0]  period_cnt_q, period_q, half_w, sample_cnt_q;
   logic              stopped, half_hit, int_clk_q, int_clk_d;
   afc_lock_e         state_q, state_d;
   logic [6:0]        lock_cnt_q;
   logic              phase_q, ld_a, ld_b, clka_d, clkb_d;
   logic [11:0]       word, stash_q, hold_a_q, hold_b_q, a_src;
   logic              stash_f_q, hold_fa_q, hold_fb_q, a_src_f, pend_a_q, pend_b_q;
   logic              access, commit, hit_ctrl, hit_stat, hit_per, hit_cnt, mapped;
   logic [31:0]       rd_d;

   // Pins cross into pclk through two flops
   afc_sync #(.W(15)) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({encode_clock_pos, core_over, core_under, core_code}),
      .q     (pin_s)
   );
   assign enc_s  = pin_s[14];
   assign ovr_s  = pin_s[13];
   assign und_s  = pin_s[12];
   assign code_s = pin_s[11:0];

   // Encode edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) enc_prev_q <= 1'b0;
      else          enc_prev_q <= enc_s;
   end
   assign rise_ev = enc_s & ~enc_prev_q;
   assign fall_ev = ~enc_s & enc_prev_q;

   assign mode     = ctrl_q[CTRL_MODE_LSB +: 2];
   assign is_full  = (mode == MODE_FULL) | (mode == MODE_LVDS);
   assign is_lvds  = (mode == MODE_LVDS);
   assign is_inter = (mode == MODE_INTER);
   assign is_simul = (mode == MODE_SIMUL);
   assign fmt_sel  = ctrl_q[CTRL_FMT_LSB +: 2];
   assign twos     = fmt_sel[1];
   assign stab_on  = fmt_sel[1] ^ fmt_sel[0];
   assign oe_n_q   = ctrl_q[CTRL_OEN_BIT];
   assign pd_q     = ctrl_q[CTRL_PD_BIT];
   assign nap      = pd_q & ~oe_n_q;

   // period counter, saturates when the clock stops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_cnt_q <= '0;
         period_q     <= '0;
      end else if (rise_ev) begin
         period_cnt_q <= '0;
         period_q     <= period_cnt_q + 16'h0001;
      end else if (!stopped) begin
         period_cnt_q <= period_cnt_q + 16'h0001;
      end
   end
   assign stopped  = (period_cnt_q == STOP_CYC);
   assign half_w   = {1'b0, period_q[CNT_W-1:1]};
   // internal fall at half the measured period
   assign half_hit = stab_on & int_clk_q & ~stopped & (half_w != '0)
                     & (period_cnt_q == half_w - 16'h0001);

   // without stabilizer the external fall is used as is
   assign int_clk_d = rise_ev ? 1'b1
                    : stab_on ? (half_hit ? 1'b0 : int_clk_q)
                    : (fall_ev ? 1'b0 : int_clk_q);

   // internal copy of the encode clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) int_clk_q <= 1'b0;
      else          int_clk_q <= int_clk_d;
   end

   // Lock and power state
   always_comb begin
      state_d = state_q;
      case (state_q)
         AFC_OFF: begin
            if (!pd_q) state_d = AFC_LOCK;
         end
         AFC_LOCK: begin
            if (rise_ev && lock_cnt_q == RELOCK_EDGES - 7'h01) state_d = AFC_READY;
         end
         AFC_READY: begin
            if (stab_on && stopped) state_d = AFC_LOCK;
         end
         default: state_d = AFC_OFF;
      endcase
      // nap or sleep drops back to off
      if (pd_q) state_d = AFC_OFF;
   end

   // Lock counter clears on a stop with stabilizer on, power-down or leaving lock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= AFC_OFF;
         lock_cnt_q <= '0;
      end else begin
         state_q <= state_d;
         if (state_q != AFC_LOCK || (stab_on && stopped)) lock_cnt_q <= '0;
         else if (rise_ev) lock_cnt_q <= lock_cnt_q + 7'h01;
      end
   end

   assign word = afc_format(code_s, ovr_s, und_s, twos);

   assign ld_a    = rise_ev & (is_full | (is_inter & ~phase_q) | (is_simul & phase_q));
   assign ld_b    = rise_ev & ~is_full & phase_q;
   assign a_src   = is_simul ? stash_q : word;
   assign a_src_f = is_simul ? stash_f_q : (ovr_s | und_s);
   assign clka_d  = is_lvds ? 1'b0
                  : is_full ? int_clk_d
                  : rise_ev ? (is_inter ? ~phase_q : phase_q) : bus_a_forwarded_clock;
   assign clkb_d  = is_full ? 1'b0
                  : rise_ev ? (is_inter ? phase_q : ~phase_q) : bus_b_forwarded_clock;

   // Stage the next words, flags and phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q   <= 1'b0;
         stash_q   <= CODE_MIN;
         stash_f_q <= 1'b0;
         hold_a_q  <= CODE_MIN;
         hold_b_q  <= CODE_MIN;
         hold_fa_q <= 1'b0;
         hold_fb_q <= 1'b0;
         pend_a_q  <= 1'b0;
         pend_b_q  <= 1'b0;
      end else begin
         pend_a_q <= ld_a;
         pend_b_q <= ld_b;
         if (rise_ev) phase_q <= ~phase_q & ~is_full;
         if (rise_ev && !phase_q) begin
            stash_q   <= word;
            stash_f_q <= ovr_s | und_s;
         end
         if (ld_a) begin
            hold_a_q  <= a_src;
            hold_fa_q <= a_src_f;
         end
         if (ld_b) begin
            hold_b_q  <= word;
            hold_fb_q <= ovr_s | und_s;
         end
      end
   end

   // data follows its clock edge by one cycle
   // flag per bus, or one pair in LVDS
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_a_bits            <= CODE_MIN;
         bus_b_bits            <= CODE_MIN;
         bus_a_range_flag      <= 1'b0;
         bus_b_range_flag      <= 1'b0;
         range_overflow_flag   <= 1'b0;
         range_overflow_flag_n <= 1'b0;
      end else begin
         if (pend_a_q) begin
            bus_a_bits            <= hold_a_q;
            bus_a_range_flag      <= hold_fa_q & ~is_lvds;
            range_overflow_flag   <= hold_fa_q & is_lvds;
            range_overflow_flag_n <= ~hold_fa_q & is_lvds;
         end
         if (pend_b_q) begin
            bus_b_bits       <= hold_b_q;
            bus_b_range_flag <= hold_fb_q;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_a_forwarded_clock    <= 1'b0;
         bus_b_forwarded_clock    <= 1'b0;
         forwarded_sample_clock   <= 1'b0;
         forwarded_sample_clock_n <= 1'b0;
      end else begin
         bus_a_forwarded_clock    <= clka_d;
         bus_b_forwarded_clock    <= clkb_d;
         forwarded_sample_clock   <= is_lvds & int_clk_d;
         forwarded_sample_clock_n <= is_lvds & ~int_clk_d;
      end
   end

   // output enable and power-down release the pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_en     <= 1'b0;
         data_ready <= 1'b0;
      end else begin
         out_en     <= ~(oe_n_q | pd_q);
         data_ready <= (state_d == AFC_READY);
      end
   end

   // Sample counter for software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)     sample_cnt_q <= '0;
      else if (rise_ev) sample_cnt_q <= sample_cnt_q + 16'h0001;
   end

   // APB decode
   assign access   = psel & penable & ~pready;
   assign commit   = psel & penable & pready;
   assign hit_ctrl = (paddr == ADDR_CTRL);
   assign hit_stat = (paddr == ADDR_STATUS);
   assign hit_per  = (paddr == ADDR_PERIOD);
   assign hit_cnt  = (paddr == ADDR_COUNT);
   assign mapped   = hit_ctrl | hit_stat | hit_per | hit_cnt;
   assign rd_d     = hit_ctrl ? {26'h0000000, ctrl_q}
                   : hit_stat ? {28'h0000000, data_ready, stab_on, nap, stopped}
                   : hit_per  ? {16'h0000, period_q}
                   : hit_cnt  ? {16'h0000, sample_cnt_q}
                   : 32'h00000000;

   // APB answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= access;
         pslverr <= access & ~mapped;
         prdata  <= (access && !pwrite) ? rd_d : 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)                           ctrl_q <= CTRL_RST;
      else if (commit && pwrite && hit_ctrl) ctrl_q <= pwdata[5:0];
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_fall_ignored: assert property (stab_on && fall_ev && !half_hit && int_clk_q |=> int_clk_q)
      else $error("external fall reached the stabilized clock");
   a_half_fall: assert property (stab_on && half_hit && !rise_ev |=> !int_clk_q)
      else $error("stabilized clock did not fall at half period");
   a_relock_edges: assert property ($rose(data_ready) |-> $past(lock_cnt_q) == 7'h63)
      else $error("ready without a hundred encode edges");
   a_zero_code: assert property (rise_ev && mode == MODE_FULL && !twos && !ovr_s && !und_s
      && code_s == CODE_MID |-> ##2 bus_a_bits == 12'h800)
      else $error("zero input not at mid code");
   a_twos_msb: assert property (rise_ev && mode == MODE_FULL && twos && !ovr_s && !und_s
      |-> ##2 bus_a_bits == ($past(code_s, 2) ^ 12'h800))
      else $error("two's complement top bit wrong");
   a_over_clamp: assert property (rise_ev && mode == MODE_FULL && !twos && ovr_s
      |-> ##2 bus_a_bits == 12'hFFF && bus_a_range_flag)
      else $error("overrange not clamped or flagged");
   a_inter_alt: assert property (rise_ev && is_inter && !phase_q
      |=> bus_a_forwarded_clock && !bus_b_forwarded_clock ##1 pend_a_q == 1'b0)
      else $error("interleaved bus A clock wrong");
   a_simul_pair: assert property (rise_ev && is_simul && phase_q
      |=> !bus_b_forwarded_clock && pend_a_q && pend_b_q)
      else $error("simultaneous buses not updated together");
   a_lvds_ovf: assert property (rise_ev && is_lvds && ovr_s
      |-> ##2 range_overflow_flag && !range_overflow_flag_n)
      else $error("LVDS overflow pair wrong");
   a_lvds_clock: assert property (rise_ev && is_lvds |=> forwarded_sample_clock
      && !forwarded_sample_clock_n)
      else $error("LVDS clock did not rise with encode");
   a_oe_hiz: assert property (oe_n_q |=> !out_en)
      else $error("outputs driven while disabled");
   a_nap_hiz: assert property (nap |=> !out_en && !data_ready)
      else $error("outputs active in nap");

   c_full:  cover property (rise_ev && mode == MODE_FULL && data_ready);
   c_simul: cover property (ld_b && is_simul);
   c_inter: cover property (ld_b && is_inter);
   c_lvds:  cover property (rise_ev && is_lvds && ovr_s);
endmodule
`default_nettype wire

// ### rtl/afc_pkg.sv
// Constants, types and helpers shared by the output formatter
// Behaviour
// - Stabilizer on: sample on rising edge, ignore external fall, make internal fall.
// - Stabilizer accepts 40% to 60% duty and keeps a 50% internal duty.
// - After a long clock stop, one hundred encode cycles relock before outputs are usable; the code relocks after a stop only with the stabilizer on.
// - Offset binary: zero is 800, positive full scale FFF, negative full scale 000.
// - Two's complement output is offset binary with the top bit inverted.
// - Out of range input raises overflow and clamps the word at the extreme code.
// - Four-level mode select: full rate, demux simultaneous, demux interleaved, LVDS.
// - Demux modes split consecutive samples across bus A and bus B at half rate.
// - Interleaved buses update on alternate cycles; simultaneous buses update together.
// - Four-level format select sets offset binary or two's complement and stabilizer.
// - Single-ended modes flag each bus separately; LVDS uses one overflow pair.
// - Bus A data changes just after its clock rises; capture on falling edge.
// - Interleaved bus B data changes after its clock rises; capture on falling edge.
// - Simultaneous bus B data changes after its clock falls; capture on rising edge.
// - LVDS data changes after the differential clock rises; capture on falling edge.
// - A delayed copy of the encode clock is forwarded as output clock.
// - Output enable high puts data, overflow and output clock in high impedance.
// - Nap keeps outputs high impedance; 100 encode cycles before data valid again.
package afc_pkg;
   localparam int          CODE_W        = 12;
   localparam logic [11:0] CODE_MAX      = 12'hFFF;
   localparam logic [11:0] CODE_MIN      = 12'h000;
   localparam logic [11:0] CODE_MID      = 12'h800;
   // Output mode codes, one per level of the mode select
   localparam logic [1:0]  MODE_FULL     = 2'h0;
   localparam logic [1:0]  MODE_SIMUL    = 2'h1;
   localparam logic [1:0]  MODE_INTER    = 2'h2;
   localparam logic [1:0]  MODE_LVDS     = 2'h3;
   // Register map (byte addresses)
   localparam int          ADDR_W        = 12;
   localparam logic [11:0] ADDR_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_STATUS   = 12'h004;
   localparam logic [11:0] ADDR_PERIOD   = 12'h008;
   localparam logic [11:0] ADDR_COUNT    = 12'h00C;
   // Control fields
   localparam int          CTRL_MODE_LSB = 0;
   localparam int          CTRL_FMT_LSB  = 2;
   localparam int          CTRL_OEN_BIT  = 4;
   localparam int          CTRL_PD_BIT   = 5;
   localparam logic [5:0]  CTRL_RST      = 6'h00;
   // Timing
   localparam int          CLK_NS        = 5;
   localparam int          STOP_NS       = 2000;
   localparam int          STOP_CYC_I    = (STOP_NS + CLK_NS - 1) / CLK_NS;
   localparam int          CNT_W         = 16;
   localparam logic [15:0] STOP_CYC      = STOP_CYC_I[15:0];
   localparam logic [6:0]  RELOCK_EDGES  = 7'h64;

   typedef enum logic [2:0] {
      AFC_OFF   = 3'b001,
      AFC_LOCK  = 3'b010,
      AFC_READY = 3'b100
   } afc_lock_e;

   // Clamp an out-of-range sample, then apply the output format
   function automatic logic [11:0] afc_format(input logic [11:0] code, input logic over,
                                              input logic under, input logic twos);
      logic [11:0] w;
      w = over ? CODE_MAX : (under ? CODE_MIN : code);
      afc_format = twos ? (w ^ CODE_MID) : w;
   endfunction
endpackage

// ### rtl/afc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module afc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ### test/afc_capture.sv
// Receiver model that latches the formatter's buses on their documented edges
`timescale 1ns/1ps
`default_nettype none
module afc_capture import afc_pkg::*; (
   input  wire logic [1:0]        mode,
   input  wire logic              arm,
   input  wire logic [CODE_W-1:0] a_bits,
   input  wire logic [CODE_W-1:0] b_bits,
   input  wire logic              a_flag,
   input  wire logic              b_flag,
   input  wire logic              lv_flag,
   input  wire logic              a_clk,
   input  wire logic              b_clk,
   input  wire logic              lv_clk,
   output logic                   a_tgl,
   output logic      [12:0]       a_val,
   output logic                   b_tgl,
   output logic      [12:0]       b_val
);
   initial begin
      a_tgl = 1'b0;
      b_tgl = 1'b0;
      a_val = 13'h0000;
      b_val = 13'h0000;
   end
   always @(negedge a_clk) begin
      if (arm && mode != MODE_LVDS) begin
         a_val = {a_flag, a_bits};
         a_tgl = ~a_tgl;
      end
   end
   always @(negedge lv_clk) begin
      if (arm && mode == MODE_LVDS) begin
         a_val = {lv_flag, a_bits};
         a_tgl = ~a_tgl;
      end
   end
   always @(b_clk) begin
      if (arm && ((mode == MODE_INTER && !b_clk) || (mode == MODE_SIMUL && b_clk))) begin
         b_val = {b_flag, b_bits};
         b_tgl = ~b_tgl;
      end
   end
endmodule
`default_nettype wire

// ### test/test_adc_output_formatter.sv
// Self-checking bench for the output formatter
`timescale 1ns/1ps
`default_nettype none
module test_adc_output_formatter import afc_pkg::*;;
   typedef struct packed {logic [31:0] m; logic [31:0] e; logic err;} afc_note_s;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rs;
   logic              encode_clock_pos, core_over, core_under, arm, twos;
   logic [CODE_W-1:0] core_code, bus_a_bits, bus_b_bits;
   logic              fa, fb, ca, cb, cs, cs_n, ro, ro_n, out_en, data_ready;
   logic              a_tgl, b_tgl;
   logic [12:0]       a_val, b_val;
   logic [1:0]        cur_mode;
   logic [13:0]       src[$];
   logic [12:0]       na[$], nb[$];
   afc_note_s         ap[$];
   int                n_errors, n_checks, k, cyc;
   real               hi_ns;

   afc_formatter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .encode_clock_pos(encode_clock_pos), .core_code(core_code),
      .core_over(core_over), .core_under(core_under), .bus_a_bits(bus_a_bits),
      .bus_b_bits(bus_b_bits), .bus_a_range_flag(fa), .bus_b_range_flag(fb),
      .bus_a_forwarded_clock(ca), .bus_b_forwarded_clock(cb), .forwarded_sample_clock(cs),
      .forwarded_sample_clock_n(cs_n), .range_overflow_flag(ro),
      .range_overflow_flag_n(ro_n), .out_en(out_en), .data_ready(data_ready));
   afc_capture u_rx (.mode(cur_mode), .arm(arm), .a_bits(bus_a_bits), .b_bits(bus_b_bits),
      .a_flag(fa), .b_flag(fb), .lv_flag(ro), .a_clk(ca), .b_clk(cb), .lv_clk(cs),
      .a_tgl(a_tgl), .a_val(a_val), .b_tgl(b_tgl), .b_val(b_val));

   // Clock and cycle ceiling
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         $display("[FAIL] %0t run too long", $time);
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic results;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction

   // APB master: note the answer, then hold the request until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [31:0] e, input logic err);
      ap.push_back('{m, e, err});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // APB answer monitor
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && ap.size() > 0) begin
         chk(prdata & ap[0].m, ap[0].e, "apb data");
         chk(32'(pslverr), 32'(ap[0].err), "apb error");
         void'(ap.pop_front());
      end
   end

   // Bus word monitors
   task automatic take(input logic bsel, input logic [12:0] got);
      if (bsel ? nb.size() == 0 : na.size() == 0) return;
      chk(32'(got), 32'(bsel ? nb.pop_front() : na.pop_front()), "bus word");
   endtask
   always @(a_tgl) take(1'b0, a_val);
   always @(b_tgl) take(1'b1, b_val);

   // Encode rise count and receiver arming after relock
   always @(posedge encode_clock_pos) begin
      k = k + 1;
      if (k == 105) begin
         repeat (6) @(posedge pclk);
         arm = 1'b1;
      end
   end

   always @(negedge encode_clock_pos) begin
      logic [13:0] s;
      logic [11:0] w;
      @(posedge pclk);
      if (k >= 104 && src.size() > 0) begin
         s = src.pop_front();
         core_code <= s[11:0];
         core_over <= s[12];
         core_under <= s[13];
         w = s[12] ? CODE_MAX : (s[13] ? CODE_MIN : s[11:0]);
         w[11] = w[11] ^ twos;
         if ((cur_mode == MODE_SIMUL || cur_mode == MODE_INTER) && k[0])
            nb.push_back({s[12] | s[13], w});
         else
            na.push_back({s[12] | s[13], w});
      end
   end

   // fixed 48 ns encode period, inside the rate limits
   // stabilizer-off runs keep hi_ns at half the period
   task automatic enc_cycles(input int n);
      repeat (n) begin
         encode_clock_pos = 1'b1;
         #(hi_ns);
         encode_clock_pos = 1'b0;
         #(48.0 - hi_ns);
      end
   endtask

   task automatic do_reset;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      k = 0;
      arm = 1'b0;
   endtask

   initial begin
      {pclk, psel, penable, pwrite, encode_clock_pos, core_over, core_under, arm} = '0;
      {paddr, pwdata, n_errors, n_checks, k, cyc} = '0;
      core_code = CODE_MID;
      rs = 32'h00002043;
      cur_mode = MODE_FULL;
      twos = 1'b0;
      hi_ns = 24.0;
      do_reset();
      chk(32'(data_ready), 32'h0, "ready at reset");
      apb(1'b0, ADDR_CTRL, 32'h0, 32'h3F, 32'h0, 1'b0);
      apb(1'b1, ADDR_STATUS, 32'hF, 32'h0, 32'h0, 1'b0);
      apb(1'b0, 12'h010, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
      // every mode and format, stabilised ones off-duty
      for (int i = 0; i < 4; i++) begin
         do_reset();
         cur_mode = i[1:0];
         twos = i[1];
         hi_ns = (i == 1) ? 19.2 : ((i == 2) ? 28.8 : 24.0);
         apb(1'b1, ADDR_CTRL, {28'h0, i[1:0], i[1:0]}, 32'h0, 32'h0, 1'b0);
         apb(1'b0, ADDR_CTRL, 32'h0, 32'h3F, {28'h0, i[1:0], i[1:0]}, 1'b0);
         src = '{14'h0800, 14'h1123, 14'h2456, 14'h0FFF, 14'h0000};
         repeat (11) begin
            rs = lfsr(rs);
            src.push_back({rs[15] & rs[16] & rs[17] & ~(&rs[14:12]), &rs[14:12], rs[11:0]});
         end
         enc_cycles(126);
         chk(32'(data_ready), 32'h1, "ready after relock");
         chk(32'(na.size() + nb.size()), 32'h0, "words not seen");
      end
      apb(1'b1, ADDR_CTRL, 32'h10, 32'h0, 32'h0, 1'b0);
      repeat (3) @(posedge pclk);
      chk(32'(out_en), 32'h0, "output enable");
      apb(1'b1, ADDR_CTRL, 32'h20, 32'h0, 32'h0, 1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0, 32'h2, 32'h2, 1'b0);
      chk(32'(out_en), 32'h0, "nap outputs");
      // Stabilizer on so that a stopped clock forces a relock
      apb(1'b1, ADDR_CTRL, 32'h4, 32'h0, 32'h0, 1'b0);
      enc_cycles(90);
      chk(32'(data_ready), 32'h0, "early ready");
      enc_cycles(20);
      chk(32'(data_ready & out_en), 32'h1, "nap recovery");
      repeat (450) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0, 32'h9, 32'h1, 1'b0);
      enc_cycles(110);
      chk(32'(data_ready), 32'h1, "relock after stop");
      repeat (4) @(posedge pclk);
      chk(32'(ap.size()), 32'h0, "apb answers");
      results();
   end
endmodule
`default_nettype wire
